// ### src/itc_regs.vh
/*
  Register map, field positions and reset values of the interval timer.
  Assumes a 32-bit APB slave port, one aligned word per register,
  byte address equal to four times the register index.
*/
`ifndef ITC_REGS_VH
`define ITC_REGS_VH

// ============================================================
// Register indices (byte address = index * 4)
`define ITC_IDX_STATUS 3'h0
`define ITC_IDX_CTRL 3'h1
`define ITC_IDX_PER_LO 3'h2
`define ITC_IDX_PER_HI 3'h3
`define ITC_IDX_CAP_LO 3'h4
`define ITC_IDX_CAP_HI 3'h5
`define ITC_ADDR_W 8

// ============================================================
// Status fields
`define ITC_ST_FLAG 0
`define ITC_ST_RUN 1

// ============================================================
// Command fields
`define ITC_CMD_IRQ_EN 0
`define ITC_CMD_FREE 1
`define ITC_CMD_START 2
`define ITC_CMD_STOP 3

// ============================================================
// Reset values and sizes
`define ITC_RST_PERIOD 32'h0000FFFF
`define ITC_RST_BIT 1'h0
`define ITC_RST_WORD 16'h0000
`define ITC_ZERO 32'h00000000
`define ITC_ONE 32'h00000001

`endif

// ### src/itc_counter.v
/*
  Down counter core of the interval timer: load, decrement, zero hold,
  reload and running state.
  Assumes load, start and stop arrive as one-cycle pulses on REF_CLK.
*/
`timescale 1ns/1ps
`include "itc_regs.vh"

module itc_counter #(
  parameter [31:0] RESET_COUNT = `ITC_RST_PERIOD
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire load,
  input wire load_stops,
  input wire [31:0] load_value,
  input wire start_cmd,
  input wire stop_cmd,
  input wire free_run,
  // State
  output reg [31:0] count_ff,
  output reg run_ff,
  output wire zero_evt
);

  reg [31:0] nxt_count;
  reg nxt_run;

  // ============================================================
  // Zero detection
  // Zero is held for one cycle, so the interval is period plus one
  assign zero_evt = run_ff && (count_ff == `ITC_ZERO);

  // ============================================================
  // Next state
  always @* begin
    nxt_count = count_ff;
    nxt_run = run_ff;
    if (load) begin
      nxt_count = load_value;
      if (load_stops) begin
        nxt_run = 1'b0;
      end
    end else if (run_ff) begin
      if (zero_evt) begin
        nxt_count = load_value;
        if (!free_run) begin
          nxt_run = 1'b0;
        end
      end else begin
        nxt_count = count_ff - `ITC_ONE;
      end
    end
    // Stop acts only while running and start only while idle, so both at once toggles the run state
    if (stop_cmd && run_ff) begin
      nxt_run = 1'b0;
    end else if (start_cmd && !run_ff) begin
      nxt_run = 1'b1;
    end
  end

  // ============================================================
  // State registers
  always @(posedge clk) begin
    if (rst) begin
      count_ff <= RESET_COUNT;
      run_ff <= `ITC_RST_BIT;
    end else begin
      count_ff <= nxt_count;
      run_ff <= nxt_run;
    end
  end

endmodule

// ### src/itc_timer.v
/*
  Interval timer: APB slave, status and command registers, reload period
  words, capture words and expiry interrupt around a 32-bit down counter.
  Assumes an APB master on REF_CLK and a synchronous active-high reset.
*/
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "itc_regs.vh"

module itc_timer #(
  parameter HAS_START_STOP = 1,
  parameter WRITABLE_PERIOD = 1,
  parameter [31:0] FIXED_PERIOD = `ITC_RST_PERIOD
) (
  // Clock and reset
  input wire REF_CLK,
  input wire RST,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`ITC_ADDR_W-1:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0] PSTRB,
  output wire PREADY,
  output reg [31:0] PRDATA,
  output reg PSLVERR,
  // Interrupt
  output wire IRQ
);

  // ============================================================
  // Declarations
  reg expiry_irq_enable_ff;
  reg free_running_mode_ff;
  reg expiry_flag_ff;
  reg [15:0] period_lo_ff;
  reg [15:0] period_hi_ff;
  reg [15:0] capture_lo_ff;
  reg [15:0] capture_hi_ff;
  reg nxt_irq_enable;
  reg nxt_free_running;
  reg nxt_flag;
  reg [15:0] nxt_period_lo;
  reg [15:0] nxt_period_hi;
  reg [15:0] nxt_capture_lo;
  reg [15:0] nxt_capture_hi;
  reg [31:0] nxt_prdata;
  reg nxt_pslverr;
  reg [15:0] rd_word;
  reg rd_hit;

  wire [2:0] reg_idx;
  wire word_aligned;
  wire in_range;
  wire acc_wr;
  wire setup_rd;
  wire wr_status;
  wire wr_cmd;
  wire wr_per_lo;
  wire wr_per_hi;
  wire wr_period;
  wire wr_capture;
  wire start_cmd;
  wire stop_cmd;
  wire [31:0] period_now;
  wire [31:0] period_next;
  wire [31:0] count;
  wire run;
  wire zero_evt;

  // ============================================================
  // APB decode
  // Zero wait states; a write takes effect at the access-phase edge
  assign PREADY = 1'b1;
  assign reg_idx = PADDR[4:2];
  assign word_aligned = (PADDR[1:0] == 2'h0);
  assign in_range = (PADDR[`ITC_ADDR_W-1:5] == 3'h0);
  assign acc_wr = PSEL && PENABLE && PWRITE && word_aligned && in_range;
  assign setup_rd = PSEL && !PENABLE && !PWRITE;

  assign wr_status = acc_wr && (reg_idx == `ITC_IDX_STATUS);
  assign wr_cmd = acc_wr && (reg_idx == `ITC_IDX_CTRL);
  assign wr_per_lo = acc_wr && (reg_idx == `ITC_IDX_PER_LO);
  assign wr_per_hi = acc_wr && (reg_idx == `ITC_IDX_PER_HI);
  assign wr_period = wr_per_lo || wr_per_hi;
  assign wr_capture = acc_wr &&
    ((reg_idx == `ITC_IDX_CAP_LO) || (reg_idx == `ITC_IDX_CAP_HI));

  // ============================================================
  // Command events
  // Event bits need the low byte lane, where they live
  assign start_cmd = wr_cmd && PSTRB[0] && PWDATA[`ITC_CMD_START];
  assign stop_cmd = wr_cmd && PSTRB[0] && PWDATA[`ITC_CMD_STOP] &&
    (HAS_START_STOP != 0);

  // ============================================================
  // Command register
  always @* begin
    nxt_irq_enable = expiry_irq_enable_ff;
    nxt_free_running = free_running_mode_ff;
    if (wr_cmd && PSTRB[0]) begin
      nxt_irq_enable = PWDATA[`ITC_CMD_IRQ_EN];
      nxt_free_running = PWDATA[`ITC_CMD_FREE];
    end
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      expiry_irq_enable_ff <= `ITC_RST_BIT;
      free_running_mode_ff <= `ITC_RST_BIT;
    end else begin
      expiry_irq_enable_ff <= nxt_irq_enable;
      free_running_mode_ff <= nxt_free_running;
    end
  end

  // ============================================================
  // Expiry flag
  // Set beats clear so a zero during a status write is not lost
  always @* begin
    nxt_flag = expiry_flag_ff;
    if (wr_status) begin
      nxt_flag = 1'b0;
    end
    if (zero_evt) begin
      nxt_flag = 1'b1;
    end
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      expiry_flag_ff <= `ITC_RST_BIT;
    end else begin
      expiry_flag_ff <= nxt_flag;
    end
  end

  assign IRQ = expiry_flag_ff && expiry_irq_enable_ff;

  // ============================================================
  // Reload period words
  // Byte lanes merge into the stored half-words
  always @* begin
    nxt_period_lo = period_lo_ff;
    nxt_period_hi = period_hi_ff;
    if (wr_per_lo && PSTRB[0]) begin
      nxt_period_lo[7:0] = PWDATA[7:0];
    end
    if (wr_per_lo && PSTRB[1]) begin
      nxt_period_lo[15:8] = PWDATA[15:8];
    end
    if (wr_per_hi && PSTRB[0]) begin
      nxt_period_hi[7:0] = PWDATA[7:0];
    end
    if (wr_per_hi && PSTRB[1]) begin
      nxt_period_hi[15:8] = PWDATA[15:8];
    end
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      period_lo_ff <= FIXED_PERIOD[15:0];
      period_hi_ff <= FIXED_PERIOD[31:16];
    end else if (WRITABLE_PERIOD != 0) begin
      period_lo_ff <= nxt_period_lo;
      period_hi_ff <= nxt_period_hi;
    end
  end

  // A fixed period ignores the written data and reloads the build value
  assign period_now = (WRITABLE_PERIOD != 0) ?
    {period_hi_ff, period_lo_ff} : FIXED_PERIOD;
  assign period_next = (WRITABLE_PERIOD != 0) ?
    {nxt_period_hi, nxt_period_lo} : FIXED_PERIOD;

  // ============================================================
  // Counter core
  // A period of zero would reload zero forever; software must avoid it
  itc_counter #(
    .RESET_COUNT(FIXED_PERIOD)
  ) u_counter (
    .clk(REF_CLK),
    .rst(RST),
    .load(wr_period),
    .load_stops(HAS_START_STOP != 0),
    .load_value(period_next),
    .start_cmd(start_cmd),
    .stop_cmd(stop_cmd),
    .free_run(free_running_mode_ff),
    .count_ff(count),
    .run_ff(run),
    .zero_evt(zero_evt)
  );

  // ============================================================
  // Capture words
  // Both halves taken in one edge so software reads a coherent value
  always @* begin
    nxt_capture_lo = capture_lo_ff;
    nxt_capture_hi = capture_hi_ff;
    if (wr_capture) begin
      nxt_capture_lo = count[15:0];
      nxt_capture_hi = count[31:16];
    end
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      capture_lo_ff <= `ITC_RST_WORD;
      capture_hi_ff <= `ITC_RST_WORD;
    end else begin
      capture_lo_ff <= nxt_capture_lo;
      capture_hi_ff <= nxt_capture_hi;
    end
  end

  // ============================================================
  // Read mux
  always @* begin
    rd_word = `ITC_RST_WORD;
    rd_hit = 1'b1;
    if (!word_aligned || !in_range) begin
      rd_hit = 1'b0;
    end else if (reg_idx == `ITC_IDX_STATUS) begin
      rd_word[`ITC_ST_FLAG] = expiry_flag_ff;
      rd_word[`ITC_ST_RUN] = run;
    end else if (reg_idx == `ITC_IDX_CTRL) begin
      rd_word[`ITC_CMD_IRQ_EN] = expiry_irq_enable_ff;
      rd_word[`ITC_CMD_FREE] = free_running_mode_ff;
    end else if (reg_idx == `ITC_IDX_PER_LO) begin
      rd_word = period_now[15:0];
    end else if (reg_idx == `ITC_IDX_PER_HI) begin
      rd_word = period_now[31:16];
    end else if (reg_idx == `ITC_IDX_CAP_LO) begin
      rd_word = capture_lo_ff;
    end else if (reg_idx == `ITC_IDX_CAP_HI) begin
      rd_word = capture_hi_ff;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ============================================================
  // Registered answer
  // Read data is sampled in the setup cycle so it can leave a flip-flop
  always @* begin
    nxt_prdata = PRDATA;
    nxt_pslverr = PSLVERR;
    if (PSEL && !PENABLE) begin
      nxt_pslverr = !rd_hit;
      nxt_prdata = `ITC_ZERO;
      if (setup_rd) begin
        nxt_prdata = {16'h0000, rd_word};
      end
    end
  end

  always @(posedge REF_CLK) begin
    if (RST) begin
      PRDATA <= `ITC_ZERO;
      PSLVERR <= 1'b0;
    end else begin
      PRDATA <= nxt_prdata;
      PSLVERR <= nxt_pslverr;
    end
  end

endmodule

// ### verification/itc_timer_properties.sv
/*
  Port-level checker for the interval timer, bound to itc_timer.
  Assumes the APB master keeps the setup/access order.
*/
`timescale 1ns/1ps

module itc_timer_properties (
  // Clock and reset
  input wire REF_CLK,
  input wire RST,
  // APB
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0] PSTRB,
  input wire PREADY,
  input wire [31:0] PRDATA,
  input wire PSLVERR,
  // Interrupt
  input wire IRQ
);
  // ============================================================
  // Shadow of the command bits
  logic en_ff, free_ff, started_ff;
  wire acc = PSEL && PENABLE && PREADY;
  wire cmd_wr = acc && PWRITE && PADDR == 8'h04 && PSTRB[0];
  wire st_rd = acc && !PWRITE && PADDR == 8'h00;
  always @(posedge REF_CLK) begin
    if (RST) begin
      en_ff <= 1'b0;
      free_ff <= 1'b0;
      started_ff <= 1'b0;
    end else if (cmd_wr) begin
      en_ff <= PWDATA[0];
      free_ff <= PWDATA[1];
      started_ff <= started_ff | PWDATA[2];
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // ============================================================
  // Properties
  AST_IRQ_NEEDS_EN: assert property (IRQ |-> en_ff)
    else $error("interrupt high with enable clear");
  AST_IRQ_DROP: assert property (cmd_wr && !PWDATA[0] |=> !IRQ [*2])
    else $error("interrupt stays after enable cleared");
  AST_RST_QUIET: assert property ($fell(RST) |-> !IRQ && !PSLVERR && PRDATA == 32'h0)
    else $error("outputs not quiet after reset");
  AST_CMD_READBACK: assert property (acc && !PWRITE && PADDR == 8'h04
    |-> PRDATA == {30'h0, free_ff, en_ff})
    else $error("command readback wrong");
  AST_IDLE_STATUS: assert property (st_rd && !started_ff |-> PRDATA[1:0] == 2'h0)
    else $error("status shows activity before any start");
  AST_FLAG_HOLD: assert property (IRQ && !(acc && PWRITE) |=> IRQ)
    else $error("interrupt dropped without a write");
  AST_UPPER_ZERO: assert property (acc && !PWRITE |-> PRDATA[31:16] == 16'h0)
    else $error("upper read bits not zero");
  AST_UNMAPPED: assert property (acc && PADDR[4:2] > 3'h5 |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  COV_IRQ: cover property ($rose(IRQ));
  COV_RUN: cover property (st_rd && PRDATA[1]);
  COV_ERR: cover property (acc && PSLVERR);
endmodule

bind itc_timer itc_timer_properties itc_timer_properties_i (.REF_CLK(REF_CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .IRQ(IRQ));

// ### verification/itc_apb_master.sv
/*
  APB master standing in for the processor.
  Assumes tasks are entered right after a rising edge.
*/
`timescale 1ns/1ps

module itc_apb_master (
  // Clock
  input wire clk,
  // APB
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr
);
  int cyc = 0;
  int edge_cyc = 0;
  always @(posedge clk) cyc <= cyc + 1;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end

  // ============================================================
  // One transfer; request held until pready is seen
  task automatic xfer(input logic w, input logic [2:0] i, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {3'h0, i, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    edge_cyc = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle cycle so the next call never reassigns psel in this step
    @(posedge clk);
  endtask
endmodule

// ### verification/itc_timer_tb_top.sv
/*
  Self-checking bench for itc_timer with default parameters and a fixed-period build without the stop command.
  Assumes a 20 MHz clock and the APB master model.
*/
`timescale 1ns/1ps

module itc_timer_tb_top;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  wire psel, penable, pwrite, pready, pslverr, irq;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [31:0] prdata2;
  localparam logic [31:0] FIXED_PER = 32'h0000FFFF;
  wire [3:0] pstrb;
  int err_count = 0;
  int cmp_count = 0;
  int tmo = 0;
  int t0, t1, a;
  logic [31:0] q, c1;
  logic e;

  initial begin
    forever #25 REF_CLK = ~REF_CLK;
  end

  itc_timer itc_timer_i (.REF_CLK(REF_CLK), .RST(RST), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .IRQ(irq));
  itc_apb_master itc_apb_master_i (.clk(REF_CLK), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));
  // Second timer on the same bus, built without the stop command (start still works) and with a fixed period
  itc_timer #(.HAS_START_STOP(0), .WRITABLE_PERIOD(0), .FIXED_PERIOD(FIXED_PER))
    itc_timer_fixed_i (.REF_CLK(REF_CLK), .RST(RST), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(),
    .PRDATA(prdata2), .PSLVERR(), .IRQ());

  // ============================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] i, input logic [31:0] d);
    itc_apb_master_i.xfer(1'b1, i, d, q, e);
  endtask
  task automatic rd(input logic [2:0] i);
    itc_apb_master_i.xfer(1'b0, i, 32'h0, q, e);
  endtask
  task automatic wirq();
    int n;
    n = 0;
    // Looked at mid-cycle, where the interrupt and the cycle count have settled
    do begin
      @(negedge REF_CLK);
      n++;
    end while (irq !== 1'b1 && n < 300);
    t1 = itc_apb_master_i.cyc;
    chk("irq", 32'h1, {31'h0, irq});
    @(posedge REF_CLK);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset();
    rd(3'h1); chk("command", 32'h0, q);
    rd(3'h0); chk("status", 32'h0, q);
    rd(3'h6); chk("unmapped", 32'h1, {q[30:0], e});
  endtask
  task automatic t_free();
    wr(3'h3, 32'h0);
    wr(3'h2, 32'h14);
    wr(3'h1, 32'h7);
    wirq();
    t0 = t1;
    wr(3'h0, 32'h0);
    wirq();
    chk("interval", 32'h15, t1 - t0);
  endtask
  task automatic t_period();
    wr(3'h2, 32'h3E8);
    rd(3'h0); chk("run after period", 32'h1, q);
    wr(3'h4, 32'h0); rd(3'h4); chk("cap", 32'h3E8, q);
    wr(3'h5, 32'h5); rd(3'h4); chk("cap stopped", 32'h3E8, q);
  endtask
  task automatic t_run();
    wr(3'h1, 32'h7);
    wr(3'h4, 32'h0); a = itc_apb_master_i.edge_cyc; rd(3'h4); c1 = q;
    wr(3'h5, 32'h0); t0 = itc_apb_master_i.edge_cyc; rd(3'h4);
    chk("decrement", c1 - (t0 - a), q);
    wr(3'h1, 32'hB); rd(3'h0); chk("stopped", 32'h0, {31'h0, q[1]});
    wr(3'h4, 32'h0); rd(3'h4); c1 = q;
    wr(3'h1, 32'h7); wr(3'h4, 32'h0); rd(3'h4);
    chk("resume", 32'h1, {31'h0, q < c1 && c1 - q < 8});
  endtask
  task automatic t_oneshot();
    wr(3'h2, 32'h14);
    wr(3'h0, 32'h0);
    wr(3'h1, 32'h4);
    repeat (40) @(posedge REF_CLK);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(3'h0); chk("one shot", 32'h1, q);
    wr(3'h4, 32'h0); rd(3'h4); chk("reloaded", 32'h14, q);
    wr(3'h1, 32'h1); @(posedge REF_CLK);
    chk("irq enabled", 32'h1, {31'h0, irq});
    wr(3'h0, 32'h3); @(posedge REF_CLK);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(3'h0); chk("status write", 32'h0, q);
  endtask
  task automatic t_options();
    wr(3'h1, 32'h8);
    rd(3'h0);
    chk("stop when idle", 32'h0, q);
    chk("stop ignored", 32'h1, {31'h0, prdata2[1]});
    wr(3'h2, 32'h14);
    a = itc_apb_master_i.edge_cyc;
    wr(3'h4, 32'h0);
    t0 = itc_apb_master_i.edge_cyc;
    rd(3'h4);
    // Fixed timer reloads its build value and keeps running through the write
    chk("fixed reload", FIXED_PER - (t0 - a - 1), prdata2);
    rd(3'h2);
    chk("period lo", 32'h14, q);
    chk("fixed period", {16'h0000, FIXED_PER[15:0]}, prdata2);
  endtask

  // ============================================================
  // Main sequence and hang guard
  always @(posedge REF_CLK) begin
    tmo <= tmo + 1;
    if (tmo == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    t_reset();
    t_free();
    t_period();
    t_run();
    t_oneshot();
    t_options();
    complete_run();
  end
endmodule
